/* hdl/order_regs.vh */
// Constants for the shared memory ordering unit.
// Assumes a single clock domain and no software-visible registers.
`ifndef ORDER_REGS_VH
`define ORDER_REGS_VH
`define ORD_OP_NONE      3'h0
`define ORD_OP_IFETCH    3'h1
`define ORD_OP_READ      3'h2
`define ORD_OP_WRITE     3'h3
`define ORD_OP_FULL_BAR  3'h4
`define ORD_OP_WRITE_BAR 3'h5
`define ORD_OP_IS_BAR    3'h6
`define ORD_SIZE_LONG    1'h0
`define ORD_SIZE_QUAD    1'h1
`define ORD_ADDR_W       48
`define ORD_QADDR_LSB    3
`define ORD_HALF_BIT     2
`define ORD_LOC_W        45
`define ORD_TOKEN_LOC    45'h1FFFFFFFFFFF
`define ORD_DRAIN_NS     1000
`define ORD_CLK_NS       50
`define ORD_DRAIN_CYC    ((`ORD_DRAIN_NS) / (`ORD_CLK_NS))
`define ORD_ST_IDLE      2'h0
`define ORD_ST_WRITE     2'h1
`define ORD_ST_READ_LO   2'h2
`define ORD_ST_READ_HI   2'h3
`endif

/* hdl/ord_word_store.v */
// Backing store for one quadword location, written per longword half.
// Assumes the owner serialises all accesses to it.
`timescale 1ns/1ps
`include "order_regs.vh"
module ord_word_store (
    // Clock and reset
    input  wire        clk,
    input  wire        resetn,
    // Write side
    input  wire [1:0]  wr_half,
    input  wire [63:0] wr_data,
    // Read side
    output wire [63:0] rd_data
);
    // ------------------------------------------------------------------
    // One word of flip-flops per longword half
    // ------------------------------------------------------------------
    // Each half owns its own register, so no variable has two writers.
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_half
            reg [31:0] held;
            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    held <= 32'h0;
                end else if (wr_half[g]) begin
                    held <= wr_data[32*g +: 32];
                end
            end
            assign rd_data[32*g +: 32] = held;
        end
    endgenerate
endmodule // ord_word_store

/* hdl/shared_memory_ordering_model.v */
// Ordering point for one shared quadword location fed by two processor ports.
// Assumes requests are synchronous to clk, held until accepted, and their fields held until answered.
`timescale 1ns/1ps
`include "order_regs.vh"
module shared_memory_ordering_model (
    // Clock and reset
    input  wire        clk,
    input  wire        resetn,
    // Requests, one slice per processor port
    input  wire [1:0]  req_valid,
    output wire [1:0]  req_ready,
    input  wire [5:0]  req_op,
    input  wire [1:0]  req_size,
    input  wire [95:0] req_addr,
    input  wire [127:0] req_wdata,
    // Responses
    output reg  [1:0]  rsp_valid,
    output reg  [127:0] rsp_rdata,
    output reg  [1:0]  rsp_split,
    // Errors and status
    output reg         misaligned,
    output reg         order_violation,
    output reg         write_pending
);
    // ------------------------------------------------------------------
    // Sequencer state and per-port decode signals
    // ------------------------------------------------------------------
    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg         sel;
    reg  [1:0]  grant;
    reg  [1:0]  dirty_long;
    reg  [1:0]  third_write;
    reg  [63:0] lo_snap;
    reg  [1:0]  wr_half;
    reg  [63:0] wr_data;
    wire [63:0] rd_data;
    wire [2:0]  op    [0:1];
    wire [47:0] addr  [0:1];
    wire [1:0]  is_wr;
    wire [1:0]  is_rd;
    wire [1:0]  is_bar;
    wire [1:0]  bad;

    // ------------------------------------------------------------------
    // Per-port request decode
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_port
            assign op[g]     = req_op[3*g +: 3];
            assign addr[g]   = req_addr[48*g +: 48];
            assign is_wr[g]  = op[g] == `ORD_OP_WRITE;
            assign is_rd[g]  = op[g] == `ORD_OP_READ || op[g] == `ORD_OP_IFETCH;
            assign is_bar[g] = op[g] == `ORD_OP_FULL_BAR || op[g] == `ORD_OP_IS_BAR;
            // Fetches must be longwords; every access naturally aligned.
            assign bad[g] = (is_rd[g] || is_wr[g]) &&
                            ((op[g] == `ORD_OP_IFETCH && req_size[g] == `ORD_SIZE_QUAD) ||
                             addr[g][1:0] != 2'h0 ||
                             (req_size[g] == `ORD_SIZE_QUAD && addr[g][`ORD_HALF_BIT]));
        end
    endgenerate

    // ------------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------------
    // One access at a time in IDLE serialises everything to this location.
    assign req_ready = (state == `ORD_ST_IDLE) ? grant : 2'h0;
    // The port not served last has priority, so a waiting write loses at most one turn
    // to the other port and is never postponed without bound.
    always @* begin
        grant = 2'h0;
        if (req_valid[~sel]) begin
            grant[~sel] = 1'b1;
        end else begin
            grant[sel] = req_valid[sel];
        end
    end

    // ------------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------------
    always @* begin
        next_state = state;
        wr_half = 2'h0;
        wr_data = 64'h0;
        case (state)
            `ORD_ST_IDLE: begin
                if (grant[0] || grant[1]) begin
                    if (is_wr[grant[1]] && !bad[grant[1]]) begin
                        next_state = `ORD_ST_WRITE;
                    end else if (is_rd[grant[1]] && !bad[grant[1]]) begin
                        next_state = `ORD_ST_READ_LO;
                    end
                end
            end
            `ORD_ST_WRITE: begin
                // Quad write hits both halves in one event.
                wr_data = req_wdata[64*sel +: 64];
                if (req_size[sel] == `ORD_SIZE_QUAD) begin
                    wr_half = 2'h3;
                end else begin
                    wr_half[addr[sel][`ORD_HALF_BIT]] = 1'b1;
                    wr_data = {2{req_wdata[64*sel +: 32]}};
                end
                next_state = `ORD_ST_IDLE;
            end
            `ORD_ST_READ_LO: begin
                next_state = (req_size[sel] == `ORD_SIZE_QUAD) ? `ORD_ST_READ_HI : `ORD_ST_IDLE;
            end
            `ORD_ST_READ_HI: begin
                next_state = `ORD_ST_IDLE;
            end
            default: begin
                next_state = `ORD_ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Backing store for the two longword halves
    // ------------------------------------------------------------------
    ord_word_store i_ord_word_store (
        .clk     (clk),
        .resetn  (resetn),
        .wr_half (wr_half),
        .wr_data (wr_data),
        .rd_data (rd_data)
    );

    // ------------------------------------------------------------------
    // Registered state, stale-half tracking and responses
    // ------------------------------------------------------------------
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= `ORD_ST_IDLE;
            sel <= 1'b0;
            dirty_long <= 2'h0;
            third_write <= 2'h0;
            lo_snap <= 64'h0;
            rsp_valid <= 2'h0;
            rsp_rdata <= 128'h0;
            rsp_split <= 2'h0;
            misaligned <= 1'b0;
            order_violation <= 1'b0;
            write_pending <= 1'b0;
        end else begin
            state <= next_state;
            rsp_valid <= 2'h0;
            // Only a request that is really taken raises the pulse; a refused one
            // waits while the sequencer is busy and is judged when it is granted.
            misaligned <= |(req_ready & bad);
            write_pending <= |(req_valid & is_wr);
            if (state == `ORD_ST_IDLE && (grant[0] || grant[1])) begin
                sel <= grant[1];
            end
            if (state == `ORD_ST_IDLE) begin
                // Full and IS barriers and quad writes clear a port's stale-half marks; write barriers do not.
                if (grant[0] && is_bar[0]) begin
                    dirty_long[0] <= 1'b0;
                end
                if (grant[1] && is_bar[1]) begin
                    dirty_long[1] <= 1'b0;
                end
            end
            if (state == `ORD_ST_WRITE) begin
                if (req_size[sel] == `ORD_SIZE_QUAD) begin
                    dirty_long[sel] <= 1'b0;
                end else begin
                    dirty_long[sel] <= 1'b1;
                end
                // Another port's write also closes the window.
                third_write[~sel] <= 1'b1;
                third_write[sel] <= 1'b0;
                rsp_valid[sel] <= 1'b1;
            end
            if (state == `ORD_ST_READ_LO) begin
                // Value is that of the latest write in access order.
                lo_snap <= rd_data;
                if (req_size[sel] != `ORD_SIZE_QUAD) begin
                    rsp_valid[sel] <= 1'b1;
                    rsp_rdata[64*sel +: 64] <= {32'h0,
                        addr[sel][`ORD_HALF_BIT] ? rd_data[63:32] : rd_data[31:0]};
                end
            end
            if (state == `ORD_ST_READ_HI) begin
                // Halves are one event unless stale longwords remain.
                rsp_valid[sel] <= 1'b1;
                rsp_rdata[64*sel +: 64] <= {rd_data[63:32], lo_snap[31:0]};
                rsp_split[sel] <= dirty_long[sel] && !third_write[sel];
                // Halves that differ from one snapshot would form a cycle. While accesses are
                // strictly serialised this cannot fire; it guards any overlap of the ports.
                if (!(dirty_long[sel] && !third_write[sel]) && rd_data != lo_snap) begin
                    order_violation <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Location scope
    // ------------------------------------------------------------------
    // Location identity is the quad address; the block models one location.
    // Address bits above the quadword offset are not compared, so a system with many
    // locations places one of these units behind each quadword's address decode.
endmodule // shared_memory_ordering_model

/* verification/order_checker_asserts.sv */
// Timing checker for port 0 of the ordering unit.
// Assumes it is bound to the unit's top module.
`timescale 1ns/1ps
`include "order_regs.vh"
module order_checker (
    // Watched ports
    input wire        clk,
    input wire        resetn,
    input wire [1:0]  req_valid,
    input wire [1:0]  req_ready,
    input wire [5:0]  req_op,
    input wire [1:0]  req_size,
    input wire [95:0] req_addr,
    input wire [1:0]  rsp_valid,
    input wire        misaligned,
    input wire        order_violation,
    input wire        write_pending
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire       acc = req_valid[0] & req_ready[0];
    wire [2:0] op  = req_op[2:0];
    wire       al  = req_addr[1:0] == 2'h0 && !(req_size[0] && req_addr[2]);
    wire       rw  = op == `ORD_OP_READ || op == `ORD_OP_WRITE || op == `ORD_OP_IFETCH;
    wire       lrd = (op == `ORD_OP_READ || op == `ORD_OP_IFETCH) && !req_size[0];
    grant_one_a: assert property (!(req_ready[0] && req_ready[1])) else $error("two grants");
    write_resp_a: assert property (acc && al && op == `ORD_OP_WRITE |-> ##2 rsp_valid[0])
        else $error("write answer late");
    long_read_a: assert property (acc && al && lrd |-> ##2 rsp_valid[0]) else $error("long read late");
    quad_read_a: assert property (acc && al && op == `ORD_OP_READ && req_size[0]
        |=> !rsp_valid[0] [*2] ##1 rsp_valid[0]) else $error("quad read timing");
    one_access_a: assert property (acc && al && rw |=> req_ready == 2'h0) else $error("second grant");
    barrier_quiet_a: assert property (acc && op >= `ORD_OP_FULL_BAR |=> !rsp_valid[0] [*2])
        else $error("barrier answered");
    bad_align_a: assert property (acc && !al && rw |=> misaligned) else $error("no misaligned pulse");
    resp_pulse_a: assert property (rsp_valid[0] |=> !rsp_valid[0]) else $error("long answer");
    viol_sticky_a: assert property (order_violation |=> order_violation) else $error("flag dropped");
    drain_bound_a: assert property (req_valid[0] && op == `ORD_OP_WRITE && !req_ready[0]
        |-> ##[1:8] req_ready[0]) else $error("write stuck");
    pend_flag_a: assert property (req_valid[0] && op == `ORD_OP_WRITE |=> write_pending)
        else $error("pending flag missing");
    cover property (acc && op == `ORD_OP_WRITE);
    cover property (acc && op == `ORD_OP_READ && req_size[0]);
    cover property (misaligned);
endmodule // order_checker
bind shared_memory_ordering_model order_checker i_order_checker (.clk, .resetn, .req_valid, .req_ready,
    .req_op, .req_size, .req_addr, .rsp_valid, .misaligned, .order_violation, .write_pending);

/* verification/far_processor.sv */
// Second processor on port 1: issues one access per go pulse.
// Fields are scrambled once the hold time has run out.
`timescale 1ns/1ps
module far_processor (
    // Clock and command
    input  wire        clk,
    input  wire        go,
    input  wire [2:0]  cmd_op,
    input  wire [63:0] cmd_data,
    // Port towards the unit
    input  wire        ready,
    output reg         valid,
    output reg  [2:0]  op,
    output reg  [47:0] addr,
    output reg  [63:0] wdata
);
    integer hold = 0;
    reg     took;
    reg     start;
    initial {valid, op, addr, wdata} = 0;
    // Ready and go are taken at the edge itself, where the unit takes the request,
    // not after it, when ready has already fallen.
    always @(posedge clk) begin
        took = valid && ready;
        start = go;
        #1;
        if (took) begin
            valid = 1'b0;
            hold = 4;
        end else if (start && !valid && hold == 0) begin
            valid = 1'b1;
            op = cmd_op;
            addr = 48'h0;
            wdata = cmd_data;
        end else if (hold > 0) begin
            hold = hold - 1;
            if (hold == 0) {op, addr, wdata} = {3'h0, ~addr, ~wdata};
        end
    end
endmodule // far_processor

/* verification/shared_memory_ordering_model_test.sv */
// Self-checking bench: port 0 driven here, port 1 by the far processor.
// Assumes the checker is bound to the unit and the constants header is on the include path.
`timescale 1ns/1ps
`include "order_regs.vh"
module shared_memory_ordering_model_test;
    reg clk = 0, resetn = 0, v0 = 0, sz0 = 0, go = 0;
    reg [2:0] op0 = 0;
    reg [47:0] a0 = 0;
    reg [63:0] d0 = 0, rd;
    wire p_v;
    wire [2:0] p_op;
    wire [47:0] p_a;
    wire [63:0] p_d;
    wire [1:0] rdy, rv, spl;
    wire [127:0] rdat;
    wire mis, viol, wp;
    integer error_cnt = 0, total_checks = 0, got, bad;
    always #25 clk = ~clk;
    shared_memory_ordering_model i_shared_memory_ordering_model (.clk(clk), .resetn(resetn),
        .req_valid({p_v, v0}), .req_ready(rdy), .req_op({p_op, op0}), .req_size({1'b1, sz0}),
        .req_addr({p_a, a0}), .req_wdata({p_d, d0}), .rsp_valid(rv), .rsp_rdata(rdat), .rsp_split(spl),
        .misaligned(mis), .order_violation(viol), .write_pending(wp));
    far_processor i_far_processor (.clk(clk), .go(go), .cmd_op(`ORD_OP_WRITE), .cmd_data(64'h13579BDF2468ACE0),
        .ready(rdy[1]), .valid(p_v), .op(p_op), .addr(p_a), .wdata(p_d));
    task chk(input [63:0] seen, input [63:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
            end
        end
    endtask
    // Holds the request fields until the answer window has passed.
    task acc(input [2:0] op, input sz, input [47:0] a, input [63:0] d, input integer lat);
        integer i;
        begin
            {op0, sz0, a0, d0, v0} = {op, sz, a, d, 1'b1};
            for (i = 0; i < 20 && rdy[0] !== 1'b1; i = i + 1) @(posedge clk) #1;
            @(posedge clk) #1;
            v0 = 0;
            {got, bad} = 0;
            // The misaligned pulse stands only in the cycle right after the accept.
            if (mis === 1'b1) bad = 1;
            // A value seen just after edge i is the one sampled at edge i + 1.
            for (i = 1; i < 5; i = i + 1) begin
                @(posedge clk) #1;
                if (rv[0] === 1'b1 && got == 0) got = i + 1;
                if (mis === 1'b1) bad = 1;
            end
            rd = rdat[63:0];
            {op0, d0} = {3'h0, ~d0};
            chk(got, lat);
        end
    endtask
    task t_same;
        begin
            acc(`ORD_OP_WRITE, 0, 0, 64'h11111111, 2);
            acc(`ORD_OP_READ, 0, 0, 0, 2);
            chk(rd[31:0], 32'h11111111);
            acc(`ORD_OP_IFETCH, 0, 0, 0, 2);
            chk(rd[31:0], 32'h11111111);
            $display("test same_location done");
        end
    endtask
    task t_split;
        begin
            acc(`ORD_OP_WRITE, 1, 0, 64'hAAAA555512345678, 2);
            acc(`ORD_OP_READ, 1, 0, 0, 3);
            chk(rd, 64'hAAAA555512345678);
            acc(`ORD_OP_WRITE, 0, 4, 64'hCAFE0001, 2);
            acc(`ORD_OP_READ, 1, 0, 0, 3);
            chk(rd, 64'hCAFE000112345678);
            chk(spl[0], 1);
            acc(`ORD_OP_WRITE_BAR, 0, 0, 0, 0);
            acc(`ORD_OP_IS_BAR, 0, 0, 0, 0);
            acc(`ORD_OP_FULL_BAR, 0, 0, 0, 0);
            acc(`ORD_OP_READ, 1, 0, 0, 3);
            chk(spl[0], 0);
            $display("test quad_split done");
        end
    endtask
    task t_other;
        integer i;
        begin
            acc(`ORD_OP_WRITE, 0, 0, 64'h5A5A0F0F, 2);
            @(posedge clk) #1 go = 1;
            for (i = 0; i < 20 && rv[1] !== 1'b1; i = i + 1) @(posedge clk) #1 go = 0;
            chk(rv[1], 1);
            acc(`ORD_OP_READ, 1, 0, 0, 3);
            chk(rd, 64'h13579BDF2468ACE0);
            chk(spl[0], 0);
            acc(`ORD_OP_READ, 1, 4, 0, 0);
            chk(bad, 1);
            chk(viol, 0);
            $display("test other_port done");
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d errors %0d", total_checks, error_cnt);
            if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #1 resetn = 1;
        t_same;
        t_split;
        t_other;
        print_verdict;
    end
    initial begin
        #100000 error_cnt = error_cnt + 1;
        print_verdict;
    end
endmodule // shared_memory_ordering_model_test
